// ### sac_pkg.sv
// Constants, types and timing counts shared by the conversion control logic.
// Assumes a 100 MHz system clock; every time is given in ns, and all but the start minimum are converted here.
package sac_pkg;

	// System clock period.
	localparam int CLK_PERIOD_NS = 10;

	// Resolution of a full conversion and the width of the step counter.
	localparam int RES_BITS = 12;
	localparam int STEP_W = 4;

	// Start pulse minimum width, kept for reference by the host side.
	localparam int START_MIN_NS = 100;

	// Clock-out pulse width; a least time, so it rounds up.
	localparam int CLKOUT_PULSE_NS = 100;
	localparam int CLKOUT_PULSE_CYC = (CLKOUT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Internal clock periods at the base rate of each model; longest times, so they round down.
	localparam int PER_SLOW_12_NS = 1667;
	localparam int PER_FAST_12_NS = 667;
	// Longest truncated conversion times for each model.
	localparam int CONV_SLOW_10_NS = 15000;
	localparam int CONV_SLOW_8_NS = 10000;
	localparam int CONV_FAST_10_NS = 6000;
	localparam int CONV_FAST_8_NS = 4000;
	// Cycles kept for the truncating step's pulse, the stop and the hand-off.
	// The short-cycle tie is only seen a few clocks into that step, so its time must be budgeted.
	localparam int STOP_SLACK_CYC = 16;
	localparam int PER_SLOW_12_CYC = PER_SLOW_12_NS / CLK_PERIOD_NS;
	localparam int PER_SLOW_10_CYC = (CONV_SLOW_10_NS / CLK_PERIOD_NS - STOP_SLACK_CYC) / 10;
	localparam int PER_SLOW_8_CYC = (CONV_SLOW_8_NS / CLK_PERIOD_NS - STOP_SLACK_CYC) / 8;
	localparam int PER_FAST_12_CYC = PER_FAST_12_NS / CLK_PERIOD_NS;
	localparam int PER_FAST_10_CYC = (CONV_FAST_10_NS / CLK_PERIOD_NS - STOP_SLACK_CYC) / 10;
	localparam int PER_FAST_8_CYC = (CONV_FAST_8_NS / CLK_PERIOD_NS - STOP_SLACK_CYC) / 8;
	localparam int PER_W = 8;

	// Result buffer depth.
	localparam int FIFO_DEPTH = 8;

	// Rate-select strap: grounded, tied to logic supply, tied to analog supply.
	typedef enum logic [1:0] {SAC_RATE_GND, SAC_RATE_LOGIC, SAC_RATE_ANALOG} sac_rate_e;

	// Output coding strap.
	typedef enum logic [1:0] {SAC_CODE_UNI, SAC_CODE_OFFSET, SAC_CODE_TWOS} sac_code_e;

	// One finished conversion as it travels through the buffer.
	typedef struct packed {
		logic [RES_BITS-1:0] code;
		logic [STEP_W-1:0] nbits;
	} sac_result_s;

	localparam int RESULT_W = RES_BITS + STEP_W;

endpackage

// ### sac_conv.sv
// Conversion control of a 12-bit successive-approximation converter, with a result buffer.
// Assumes start, comparator, short-cycle and straps come from outside clk_i's domain.
`timescale 1ns/1ps

// Plain first-word-fall-through FIFO; width and depth shape its storage.
module sac_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW:0] wr_ptr_r;
	logic [AW:0] rd_ptr_r;
	logic full;
	logic empty;

	// One spare pointer bit tells full from empty.
	assign full = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
	assign empty = (wr_ptr_r == rd_ptr_r);
	assign in_ready_o = !full;
	assign out_valid_o = !empty;
	assign out_data_o = mem_r[rd_ptr_r[AW-1:0]];

	// Write side.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_ptr_r <= '0;
		end else if (in_valid_i && !full) begin
			mem_r[wr_ptr_r[AW-1:0]] <= in_data_i;
			wr_ptr_r <= wr_ptr_r + 1'b1;
		end
	end

	// Read side.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_ptr_r <= '0;
		end else if (out_ready_i && !empty) begin
			rd_ptr_r <= rd_ptr_r + 1'b1;
		end
	end
endmodule

module sac_conv import sac_pkg::*; #(
	parameter bit FAST_MODEL = 1'b0,
	parameter int DEPTH = FIFO_DEPTH
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	input wire logic compare_i,
	input wire logic short_cycle_i,
	input wire logic [1:0] rate_sel_i,
	input wire logic [1:0] coding_i,
	output logic [RES_BITS-1:0] data_o,
	output logic serial_o,
	output logic eoc_o,
	output logic clk_out_o,
	output logic res_valid_o,
	input wire logic res_ready_i,
	output sac_result_s res_data_o
);
	typedef enum logic [1:0] {SAC_IDLE, SAC_CONV, SAC_PUSH} sac_state_e;

	sac_state_e state_r;
	logic start_s1_r, start_s2_r, start_s3_r;
	logic cmp_s1_r, cmp_s2_r;
	logic short_s1_r, short_s2_r;
	logic [1:0] rate_s1_r, rate_s2_r;
	logic [1:0] code_s1_r, code_s2_r;
	logic [RES_BITS-1:0] sar_r;
	logic [STEP_W-1:0] step_r;
	logic [STEP_W-1:0] nbits_r;
	logic [STEP_W-1:0] bitpos;
	logic [PER_W-1:0] phase_r;
	logic [PER_W-1:0] per_max_r;
	logic start_fall;
	logic tick;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [RESULT_W-1:0] fifo_out_data;
	sac_result_s push_data;

	// Internal clock period for the model and rate strap, as a terminal count.
	function automatic logic [PER_W-1:0] per_sel(input logic [1:0] rate);
		logic [PER_W-1:0] p;
		p = PER_W'(FAST_MODEL ? PER_FAST_12_CYC - 1 : PER_SLOW_12_CYC - 1);
		case (rate)
			SAC_RATE_LOGIC: p = PER_W'(FAST_MODEL ? PER_FAST_10_CYC - 1 : PER_SLOW_10_CYC - 1);
			SAC_RATE_ANALOG: p = PER_W'(FAST_MODEL ? PER_FAST_8_CYC - 1 : PER_SLOW_8_CYC - 1);
			default: p = PER_W'(FAST_MODEL ? PER_FAST_12_CYC - 1 : PER_SLOW_12_CYC - 1);
		endcase
		return p;
	endfunction

	// Start, comparator, short-cycle and strap pins pass two flip-flops; the third start stage serves the edge detector and the idle status check.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			start_s1_r <= 1'b0;
			start_s2_r <= 1'b0;
			start_s3_r <= 1'b0;
			cmp_s1_r <= 1'b0;
			cmp_s2_r <= 1'b0;
			short_s1_r <= 1'b1;
			short_s2_r <= 1'b1;
			rate_s1_r <= 2'h0;
			rate_s2_r <= 2'h0;
			code_s1_r <= 2'h0;
			code_s2_r <= 2'h0;
		end else begin
			start_s1_r <= start_i;
			start_s2_r <= start_s1_r;
			start_s3_r <= start_s2_r;
			cmp_s1_r <= compare_i;
			cmp_s2_r <= cmp_s1_r;
			short_s1_r <= short_cycle_i;
			short_s2_r <= short_s1_r;
			rate_s1_r <= rate_sel_i;
			rate_s2_r <= rate_s1_r;
			code_s1_r <= coding_i;
			code_s2_r <= code_s1_r;
		end
	end

	// width not policed.
	// A start pulse shorter than one clock may be missed; the host keeps it long enough.
	// falling edge detect.
	assign start_fall = start_s3_r && !start_s2_r;
	assign tick = (state_r == SAC_CONV) && (phase_r == per_max_r);
	assign bitpos = STEP_W'(RES_BITS - 1) - step_r;

	// Conversion sequencer: state, step counter, approximation register.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= SAC_IDLE;
			step_r <= '0;
			nbits_r <= '0;
			sar_r <= '0;
		end else if (start_fall) begin
			state_r <= SAC_CONV;
			step_r <= '0;
			sar_r <= {1'b1, {(RES_BITS-1){1'b0}}};
		end else begin
			case (state_r)
				SAC_CONV: begin
					if (step_r != '0 && !short_s2_r && phase_r >= PER_W'(CLKOUT_PULSE_CYC)) begin
						// truncated conversion.
						// Stopping once the step's pulse is out keeps the pulse whole and the time short.
						sar_r[bitpos] <= 1'b0;
						nbits_r <= step_r;
						state_r <= SAC_PUSH;
					end else if (tick) begin
						sar_r[bitpos] <= cmp_s2_r;
						if (step_r == STEP_W'(RES_BITS - 1)) begin
							nbits_r <= STEP_W'(RES_BITS);
							state_r <= SAC_PUSH;
						end else begin
							sar_r[bitpos - 1'b1] <= 1'b1;
							step_r <= step_r + 1'b1;
						end
					end
				end
				SAC_PUSH: begin
					// The buffer stalls the handoff here rather than drop a result.
					if (fifo_in_ready) begin
						state_r <= SAC_IDLE;
					end
				end
				SAC_IDLE: begin
					state_r <= SAC_IDLE;
				end
				default: begin
					state_r <= SAC_IDLE;
				end
			endcase
		end
	end

	// bounded conversion time; a full buffer stalls the hand-off with status high, without limit.
	// Period is caught at start so a strap change mid-conversion cannot skew a step.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phase_r <= '0;
			per_max_r <= PER_W'(PER_SLOW_12_CYC - 1);
		end else if (start_fall) begin
			phase_r <= '0;
			per_max_r <= per_sel(rate_s2_r);
		end else if (tick) begin
			phase_r <= '0;
		end else if (state_r == SAC_CONV) begin
			phase_r <= phase_r + 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			clk_out_o <= 1'b0;
		end else begin
			clk_out_o <= (state_r == SAC_CONV) && !start_fall && (phase_r < PER_W'(CLKOUT_PULSE_CYC));
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			serial_o <= 1'b1;
		end else if (tick && !(step_r != '0 && !short_s2_r)) begin
			serial_o <= !cmp_s2_r;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			data_o <= {RES_BITS{1'b1}};
		end else if (code_s2_r == SAC_CODE_TWOS) begin
			data_o <= {sar_r[RES_BITS-1], ~sar_r[RES_BITS-2:0]};
		end else begin
			data_o <= ~sar_r;
		end
	end

	// status during conversion.
	// Status stays high through reset and drops once the result is handed off, or in the first idle after reset with no conversion yet.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			eoc_o <= 1'b1;
		end else if (start_fall || state_r == SAC_CONV) begin
			eoc_o <= 1'b1;
		end else if (state_r == SAC_PUSH && fifo_in_ready) begin
			eoc_o <= 1'b0;
		end else if (state_r == SAC_IDLE && start_s2_r == start_s3_r) begin
			eoc_o <= (nbits_r == '0) ? 1'b0 : eoc_o;
		end
	end

	assign push_data.code = sar_r;
	assign push_data.nbits = nbits_r;

	sac_fifo #(
		.WIDTH(RESULT_W),
		.DEPTH(DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.in_valid_i(state_r == SAC_PUSH),
		.in_ready_o(fifo_in_ready),
		.in_data_i(push_data),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(fifo_out_ready),
		.out_data_o(fifo_out_data)
	);

	// Registered output stage so the result port comes straight from flip-flops.
	assign fifo_out_ready = !res_valid_o || res_ready_i;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			res_valid_o <= 1'b0;
			res_data_o <= '0;
		end else if (fifo_out_ready) begin
			res_valid_o <= fifo_out_valid;
			res_data_o <= fifo_out_data;
		end
	end
endmodule

// ### sac_conv_monitor.sv
// Checker for the conversion control ports.
// Assumes it is bound into every sac_conv instance.
`timescale 1ns/1ps
module sac_conv_monitor import sac_pkg::*; #(
	parameter bit FAST_MODEL = 1'b0,
	parameter int DEPTH = FIFO_DEPTH
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	input wire logic compare_i,
	input wire logic short_cycle_i,
	input wire logic [1:0] rate_sel_i,
	input wire logic [1:0] coding_i,
	input wire logic [RES_BITS-1:0] data_o,
	input wire logic serial_o,
	input wire logic eoc_o,
	input wire logic clk_out_o,
	input wire logic res_valid_o,
	input wire logic res_ready_i,
	input wire sac_result_s res_data_o
);
	logic started_r;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// Remembers that a conversion ran, since the first idle after reset drops the status with no result.
	always_ff @(posedge clk_i) begin
		started_r <= rst_i ? 1'b0 : (started_r | clk_out_o);
	end
	// A clock-out pulse is ten system cycles high.
	sequence pulse_hi;
		clk_out_o[*5] ##1 clk_out_o[*5];
	endsequence
	// An offered result stays up and unchanged.
	sequence held;
		res_valid_o && $stable(res_data_o);
	endsequence
	a_reset_outputs: assert property (disable iff (1'b0) rst_i ##1 rst_i |=>
		eoc_o && !clk_out_o && !res_valid_o && serial_o && data_o == 12'hfff) else $error("outputs not idle in reset");
	a_start_busy: assert property ($fell(start_i) |-> ##[1:8] eoc_o) else $error("start fall left status low");
	a_clkout_width: assert property ($rose(clk_out_o) |-> pulse_hi ##1 !clk_out_o) else $error("clock pulse width");
	a_first_pulse: assert property ($rose(eoc_o) |-> ##[1:2] $rose(clk_out_o)) else $error("no first pulse");
	a_data_hold: assert property (!eoc_o && !$past(eoc_o) && coding_i == $past(coding_i) &&
		coding_i == $past(coding_i, 2) && coding_i == $past(coding_i, 3) && coding_i == $past(coding_i, 4)
		|-> $stable(data_o) && $stable(serial_o)) else $error("result moved");
	a_step_spacing: assert property ($changed(data_o) |=> $stable(data_o)[*8]) else $error("data changed twice");
	a_serial_busy: assert property ($changed(serial_o) |-> eoc_o) else $error("serial moved when done");
	a_done_result: assert property ($fell(eoc_o) && started_r |-> ##[0:3] res_valid_o) else $error("no result");
	a_result_held: assert property (res_valid_o && !res_ready_i |=> held) else $error("result dropped");
	a_clkout_idle: assert property (!eoc_o |-> !clk_out_o) else $error("clock pulse when done");
endmodule

bind sac_conv sac_conv_monitor #(.FAST_MODEL(FAST_MODEL), .DEPTH(DEPTH)) mon_u (.*);

// ### sac_host_model.sv
// Host and analog front end: start pulses, comparator and short-cycle tie.
// Assumes the converter outputs settle just after clk_i rising edges.
`timescale 1ns/1ps
module sac_host_model import sac_pkg::*; (
	input wire logic clk_i,
	input wire logic [RES_BITS-1:0] data_i,
	input wire logic [1:0] coding_i,
	output logic start_o = 1'b0,
	output logic compare_o = 1'b0,
	output logic short_o = 1'b1
);
	logic [RES_BITS-1:0] vin_r = 12'h000;
	int nb_r = 12;
	logic [RES_BITS-1:0] trial;
	// Undo the complementary coding to recover the trial value.
	assign trial = (coding_i == 2'h2) ? {data_i[11], ~data_i[10:0]} : ~data_i;
	// Comparator and strap wire lag one clock, as a slow analog path would.
	always_ff @(posedge clk_i) begin
		compare_o <= (trial <= vin_r);
		short_o <= (nb_r >= RES_BITS) ? 1'b1 : data_i[RES_BITS-1-nb_r];
	end
	// one start per conversion, no external clocking.
	task automatic start_conv(input logic [11:0] vin, input int nb);
		@(posedge clk_i);
		vin_r <= vin;
		nb_r <= nb;
		start_o <= 1'b1;
		repeat (16) @(posedge clk_i);
		start_o <= 1'b0;
	endtask
endmodule

// ### sac_conv_tb.sv
// Self-checking bench for sac_conv with the host model.
// Assumes the slow model; the comparator model settles each trial.
`timescale 1ns/1ps
module sac_conv_tb import sac_pkg::*; ();
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [1:0] rate_sel_i = 2'h0;
	logic [1:0] coding_i = 2'h0;
	logic res_ready_i = 1'b0;
	logic start_i, compare_i, short_cycle_i, serial_o, eoc_o, clk_out_o, res_valid_o;
	logic [RES_BITS-1:0] data_o;
	sac_result_s res_data_o;
	int miscompares = 0;
	int n_tests = 0;
	int cyc = 0;
	sac_conv #(.FAST_MODEL(1'b0), .DEPTH(FIFO_DEPTH)) dut_u (.*);
	sac_host_model host_u (.clk_i(clk_i), .data_i(data_o), .coding_i(coding_i), .start_o(start_i),
		.compare_o(compare_i), .short_o(short_cycle_i));
	// System clock.
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	// Cuts a hang short; the plan needs about 21500 cycles.
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 40000) begin
			miscompares++;
			conclude();
		end
	end
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic conclude();
		if (miscompares == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// One conversion; counts busy cycles and gathers serial bits at each later clock-out rise.
	task automatic run_conv(input logic [11:0] vin, input int nb, output int dur, output logic [11:0] ser);
		logic prev;
		int w;
		prev = 1'b0;
		w = 0;
		dur = 0;
		ser = 12'h000;
		host_u.start_conv(vin, nb);
		while (eoc_o !== 1'b1 && w < 20) begin
			@(posedge clk_i);
			w++;
		end
		while (eoc_o !== 1'b0 && dur < 3000) begin
			@(posedge clk_i);
			dur++;
			if (clk_out_o && !prev && w + dur > 12) ser = {ser[10:0], serial_o};
			prev = clk_out_o;
		end
		ser = {ser[10:0], serial_o};
		chk("status", 16'h0, {15'h0, eoc_o});
	endtask
	// Takes one buffered result; an edge passes first so the last handshake has landed.
	task automatic take(input logic [11:0] code, input int nb);
		int w;
		w = 0;
		@(posedge clk_i);
		while (res_valid_o !== 1'b1 && w < 50) begin
			@(posedge clk_i);
			w++;
		end
		chk("result", {code, nb[3:0]}, res_data_o);
		res_ready_i <= 1'b1;
		@(posedge clk_i);
		res_ready_i <= 1'b0;
	endtask
	// Full conversions in every coding.
	task automatic t_coding();
		int dur;
		logic [11:0] ser;
		logic [11:0] v;
		v = 12'ha5c;
		for (int c = 0; c < 3; c++) begin
			coding_i <= c[1:0];
			@(posedge clk_i);
			run_conv(v, 12, dur, ser);
			chk("parallel", {4'h0, (c == 2) ? {v[11], ~v[10:0]} : ~v}, {4'h0, data_o});
			chk("serial", {4'h0, ~v}, {4'h0, ser});
			chk("time", 16'h1, {15'h0, dur <= 2000});
			take(v, 12);
		end
	endtask
	// Truncated conversions; the limit allows the truncating step and a short hand-off.
	task automatic t_short();
		int dur;
		logic [11:0] ser;
		logic [11:0] m;
		coding_i <= 2'h0;
		for (int nb = 8; nb <= 10; nb += 2) begin
			rate_sel_i <= (nb == 10) ? 2'h1 : 2'h2;
			@(posedge clk_i);
			m = 12'h3c6 & (12'hfff << (12 - nb));
			run_conv(12'h3c6, nb, dur, ser);
			chk("parallel", {4'h0, ~m}, {4'h0, data_o});
			chk("fast", 16'h1, {15'h0, dur <= ((nb == 10) ? 1500 : 1000)});
			take(m, nb);
		end
	endtask
	// A start in mid-conversion restarts it and yields one result.
	task automatic t_abort();
		int dur;
		logic [11:0] ser;
		rate_sel_i <= 2'h0;
		host_u.start_conv(12'h0f0, 12);
		repeat (300) @(posedge clk_i);
		run_conv(12'h90f, 12, dur, ser);
		chk("restart", 16'h1, {15'h0, dur > 1900});
		take(12'h90f, 12);
		repeat (3) @(posedge clk_i);
		chk("one result", 16'h0, {15'h0, res_valid_o});
	endtask
	// Reader stalled: the buffer fills, the next conversion waits busy, then all drain in order.
	task automatic t_fill();
		int dur;
		logic [11:0] ser;
		rate_sel_i <= 2'h2;
		for (int i = 0; i < 9; i++) run_conv({i[3:0], 8'h50}, 8, dur, ser);
		host_u.start_conv(12'hff0, 8);
		repeat (1300) @(posedge clk_i);
		chk("stalled", 16'h1, {15'h0, eoc_o});
		for (int i = 0; i < 9; i++) take({i[3:0], 8'h50}, 8);
		take(12'hff0, 8);
		repeat (3) @(posedge clk_i);
		chk("empty", 16'h0, {15'h0, res_valid_o});
	endtask
	// Reset for three cycles, checked inside, then the scenarios.
	initial begin
		repeat (2) @(posedge clk_i);
		chk("reset status", 16'h1, {15'h0, eoc_o});
		chk("reset data", 16'h0fff, {4'h0, data_o});
		@(posedge clk_i);
		rst_i <= 1'b0;
		t_coding();
		t_short();
		t_abort();
		t_fill();
		conclude();
	end
endmodule
